// ===== hdl/decode_pkg.sv
// shared opcodes, field codes, cycle costs and carrier types of the decoder
package decode_pkg;

  typedef logic [23:0] cyc_t;

  typedef enum logic [5:0] {
    ST_OPC = 6'h01,
    ST_MODRM = 6'h02,
    ST_ADJ = 6'h04,
    ST_DISP = 6'h08,
    ST_IMM = 6'h10,
    ST_EXEC = 6'h20
  } dstate_e;

  typedef enum logic [5:0] {
    OP_BAD, OP_DIVIDE, OP_ADJ_MUL, OP_ADJ_DIV, OP_BYTE_EXT, OP_WORD_EXT,
    OP_SHIFT1, OP_SHIFT_CNT_REG, OP_SHIFT_IMM, OP_AND_IMM, OP_AND_ACC,
    OP_TEST_RM, OP_GRP3, OP_TEST_IMM, OP_NOT, OP_TEST_ACC,
    OP_STR_MOVE, OP_STR_CMP, OP_STR_SCAN, OP_STR_LOAD, OP_STR_STORE,
    OP_STR_IN, OP_STR_OUT, OP_CALL_NEAR, OP_GRP5, OP_CALL_IND, OP_JMP_IND,
    OP_CALL_FAR_IND, OP_JMP_FAR_IND, OP_CALL_FAR, OP_JMP_FAR,
    OP_RET_NEAR, OP_RET_NEAR_IMM, OP_RET_FAR, OP_RET_FAR_IMM
  } op_e;

  typedef enum logic [2:0] {
    ROTATE_LEFT = 3'h0,
    ROTATE_RIGHT = 3'h1,
    ROTATE_CARRY_LEFT = 3'h2,
    ROTATE_CARRY_RIGHT = 3'h3,
    SHIFT_LEFT = 3'h4,
    LOGICAL_SHIFT_RIGHT = 3'h5,
    SHIFT_UNDEF = 3'h6,
    ARITHMETIC_SHIFT_RIGHT = 3'h7
  } shift_op_e;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fetch_s;

  typedef struct packed {
    logic valid;
    logic bad;
    op_e op;
    shift_op_e shift_op;
    logic wide;
    logic mem;
    logic rep;
    logic rep_z;
    cyc_t cycles;
  } dec_s;

  // opcodes; for w-type ones the w bit is zero here
  localparam logic [7:0] OPC_GRP3 = 8'hF6;
  localparam logic [7:0] OPC_ADJ_MUL = 8'hD4;
  localparam logic [7:0] OPC_ADJ_DIV = 8'hD5;
  localparam logic [7:0] ADJ_TAIL = 8'h0A;
  localparam logic [7:0] OPC_BYTE_EXT = 8'h98;
  localparam logic [7:0] OPC_WORD_EXT = 8'h99;
  localparam logic [7:0] OPC_SHIFT1 = 8'hD0;
  localparam logic [7:0] OPC_SHIFT_CNT = 8'hD2;
  localparam logic [7:0] OPC_SHIFT_IMM = 8'hC0;
  localparam logic [7:0] OPC_AND_IMM = 8'h80;
  localparam logic [7:0] OPC_AND_ACC = 8'h24;
  localparam logic [7:0] OPC_TEST_RM = 8'h84;
  localparam logic [7:0] OPC_TEST_ACC = 8'hA8;
  localparam logic [7:0] OPC_STR_MOVE = 8'hA4;
  localparam logic [7:0] OPC_STR_CMP = 8'hA6;
  localparam logic [7:0] OPC_STR_SCAN = 8'hAE;
  localparam logic [7:0] OPC_STR_LOAD = 8'hAC;
  localparam logic [7:0] OPC_STR_STORE = 8'hAA;
  localparam logic [7:0] OPC_STR_IN = 8'h6C;
  localparam logic [7:0] OPC_STR_OUT = 8'h6E;
  localparam logic [7:0] OPC_REP = 8'hF2;
  localparam logic [7:0] OPC_CALL_NEAR = 8'hE8;
  localparam logic [7:0] OPC_GRP5 = 8'hFF;
  localparam logic [7:0] OPC_CALL_FAR = 8'h9A;
  localparam logic [7:0] OPC_JMP_FAR = 8'hEA;
  localparam logic [7:0] OPC_RET_NEAR = 8'hC3;
  localparam logic [7:0] OPC_RET_NEAR_IMM = 8'hC2;
  localparam logic [7:0] OPC_RET_FAR = 8'hCB;
  localparam logic [7:0] OPC_RET_FAR_IMM = 8'hCA;

  // extension field codes and modifier codes
  localparam logic [2:0] EXT_TEST = 3'h0;
  localparam logic [2:0] EXT_NOT = 3'h2;
  localparam logic [2:0] EXT_DIVIDE = 3'h7;
  localparam logic [2:0] EXT_AND = 3'h4;
  localparam logic [2:0] EXT_CALL_IND = 3'h2;
  localparam logic [2:0] EXT_CALL_FAR_IND = 3'h3;
  localparam logic [2:0] EXT_JMP_IND = 3'h4;
  localparam logic [2:0] EXT_JMP_FAR_IND = 3'h5;
  localparam logic [1:0] MOD_NO_DISP = 2'h0;
  localparam logic [1:0] MOD_DISP8 = 2'h1;
  localparam logic [1:0] MOD_DISP16 = 2'h2;
  localparam logic [1:0] MOD_REG = 2'h3;
  localparam logic [2:0] RM_DIRECT = 3'h6;

  // cycle costs
  localparam cyc_t CYC_DIV_RB = 24'h00002C;
  localparam cyc_t CYC_DIV_RW = 24'h000035;
  localparam cyc_t CYC_DIV_MB = 24'h000032;
  localparam cyc_t CYC_DIV_MW = 24'h00003B;
  localparam cyc_t CYC_DIV_SPREAD = 24'h000008;
  localparam cyc_t CYC_ADJ_MUL = 24'h000013;
  localparam cyc_t CYC_ADJ_DIV = 24'h00000F;
  localparam cyc_t CYC_BYTE_EXT = 24'h000002;
  localparam cyc_t CYC_WORD_EXT = 24'h000004;
  localparam cyc_t CYC_SH1_R = 24'h000002;
  localparam cyc_t CYC_SH1_M = 24'h00000F;
  localparam cyc_t CYC_SHN_R = 24'h000005;
  localparam cyc_t CYC_SHN_M = 24'h000011;
  localparam cyc_t CYC_AND_IMM_R = 24'h000004;
  localparam cyc_t CYC_AND_IMM_M = 24'h000010;
  localparam cyc_t CYC_ACC_B = 24'h000003;
  localparam cyc_t CYC_ACC_W = 24'h000004;
  localparam cyc_t CYC_TEST_RM_R = 24'h000003;
  localparam cyc_t CYC_TEST_IMM_R = 24'h000004;
  localparam cyc_t CYC_TEST_M = 24'h00000A;
  localparam cyc_t CYC_NOT = 24'h000003;
  localparam cyc_t CYC_WORD_XFER = 24'h000004;
  localparam cyc_t CYC_CALL_NEAR = 24'h000013;
  localparam cyc_t CYC_CALL_IND_R = 24'h000011;
  localparam cyc_t CYC_CALL_IND_M = 24'h00001B;
  localparam cyc_t CYC_JMP_IND_R = 24'h00000B;
  localparam cyc_t CYC_JMP_IND_M = 24'h000015;
  localparam cyc_t CYC_CALL_FAR_IND = 24'h000036;
  localparam cyc_t CYC_JMP_FAR_IND = 24'h000022;
  localparam cyc_t CYC_CALL_FAR = 24'h00001F;
  localparam cyc_t CYC_JMP_FAR = 24'h00000E;
  localparam cyc_t CYC_RET_NEAR = 24'h000014;
  localparam cyc_t CYC_RET_NEAR_IMM = 24'h000016;
  localparam cyc_t CYC_RET_FAR = 24'h00001E;
  localparam cyc_t CYC_RET_FAR_IMM = 24'h000021;

endpackage

// ===== hdl/cycle_timer.sv
// down counter that pulses once a loaded execution time has run out
`timescale 1ns/10ps
module cycle_timer
  import decode_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic load,
  input wire cyc_t load_val,
  output logic done
);

  cyc_t count_ff;
  cyc_t nxt_count;
  logic done_ff;
  logic nxt_done;

  always_comb begin
    nxt_count = count_ff;
    nxt_done = 1'b0;
    if (load) begin
      nxt_count = load_val;
    end else if (count_ff != '0) begin
      nxt_count = count_ff - 24'h000001;
      nxt_done = (count_ff == 24'h000001);
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      count_ff <= '0;
      done_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

// ===== hdl/opcode_decode.sv
// byte-serial opcode decoder that times each instruction it recognises
`timescale 1ns/10ps
// Function
// - signed divide: group F6/F7 extension 111, 44-52/53-61/50-58/59-67 cycles
// - multiply adjust: D4 then 0A, 19 cycles
// - divide adjust: D5 then 0A, 15 cycles
// - byte extend 98 takes 2 cycles, word extend 99 takes 4
// - shift by one D0/D1: 2 register, 15 memory; field picks operation
// - shift by count register or immediate: 5+n register, 17+n memory
// - and immediate 80/81 extension 100: 4 register, 16 memory
// - and immediate accumulator 24/25: 3 byte, 4 word
// - test register/memory with register 84/85: 3 register, 10 memory
// - test immediate F6/F7 extension 000: 4 register, 10 memory
// - test immediate accumulator A8/A9: 3 byte, 4 word
// - invert F6/F7 extension 010 takes 3 cycles
// - string move 14 cycles, string compare 22 cycles
// - string scan 15, load 12, store 10 cycles
// - string port input and output take 14 cycles each
// - repeat prefix times count register; F3 only for compare and scan
// - word operation adds four cycles per memory transfer on marked costs
// - direct near call E8 with two displacement bytes, 19 cycles
// - FF extension 010 call 17/27, extension 100 jump 11/21
// - far direct call 9A 31 cycles, jump EA 14, four bytes follow
// - FF extension 011 call 54, 101 jump 34; register form refused
// - returns take 20, 22, 30 and 33 cycles
// - modifier selects register, no, 8-bit or 16-bit displacement
module opcode_decode
  import decode_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire fetch_s fetch_in,
  input wire logic [7:0] count_reg_low_byte,
  input wire logic [15:0] count_register,
  output logic fetch_ready,
  output logic busy,
  output dec_s dec_out
);

  function automatic op_e classify(input logic [7:0] b);
    op_e o;
    o = OP_BAD;
    case (b[7:1])
      OPC_GRP3[7:1]: o = OP_GRP3;
      OPC_SHIFT1[7:1]: o = OP_SHIFT1;
      OPC_SHIFT_CNT[7:1]: o = OP_SHIFT_CNT_REG;
      OPC_SHIFT_IMM[7:1]: o = OP_SHIFT_IMM;
      OPC_AND_IMM[7:1]: o = OP_AND_IMM;
      OPC_AND_ACC[7:1]: o = OP_AND_ACC;
      OPC_TEST_RM[7:1]: o = OP_TEST_RM;
      OPC_TEST_ACC[7:1]: o = OP_TEST_ACC;
      OPC_STR_MOVE[7:1]: o = OP_STR_MOVE;
      OPC_STR_CMP[7:1]: o = OP_STR_CMP;
      OPC_STR_SCAN[7:1]: o = OP_STR_SCAN;
      OPC_STR_LOAD[7:1]: o = OP_STR_LOAD;
      OPC_STR_STORE[7:1]: o = OP_STR_STORE;
      OPC_STR_IN[7:1]: o = OP_STR_IN;
      OPC_STR_OUT[7:1]: o = OP_STR_OUT;
      default: o = OP_BAD;
    endcase
    case (b)
      OPC_ADJ_MUL: o = OP_ADJ_MUL;
      OPC_ADJ_DIV: o = OP_ADJ_DIV;
      OPC_BYTE_EXT: o = OP_BYTE_EXT;
      OPC_WORD_EXT: o = OP_WORD_EXT;
      OPC_CALL_NEAR: o = OP_CALL_NEAR;
      OPC_GRP5: o = OP_GRP5;
      OPC_CALL_FAR: o = OP_CALL_FAR;
      OPC_JMP_FAR: o = OP_JMP_FAR;
      OPC_RET_NEAR: o = OP_RET_NEAR;
      OPC_RET_NEAR_IMM: o = OP_RET_NEAR_IMM;
      OPC_RET_FAR: o = OP_RET_FAR;
      OPC_RET_FAR_IMM: o = OP_RET_FAR_IMM;
      default: o = o;
    endcase
    return o;
  endfunction

  // the extension field narrows a group; encodings left out here are bad
  function automatic op_e resolve(input op_e o, input logic [7:0] m);
    op_e r;
    r = o;
    case (o)
      OP_GRP3: begin
        case (m[5:3])
          EXT_DIVIDE: r = OP_DIVIDE;
          EXT_TEST: r = OP_TEST_IMM;
          EXT_NOT: r = OP_NOT;
          default: r = OP_BAD;
        endcase
      end
      OP_AND_IMM: r = (m[5:3] == EXT_AND) ? OP_AND_IMM : OP_BAD;
      OP_GRP5: begin
        case (m[5:3])
          EXT_CALL_IND: r = OP_CALL_IND;
          EXT_JMP_IND: r = OP_JMP_IND;
          EXT_CALL_FAR_IND: r = OP_CALL_FAR_IND;
          EXT_JMP_FAR_IND: r = OP_JMP_FAR_IND;
          default: r = OP_BAD;
        endcase
        if ((r == OP_CALL_FAR_IND || r == OP_JMP_FAR_IND) &&
            m[7:6] == MOD_REG) begin
          r = OP_BAD;
        end
      end
      OP_SHIFT1, OP_SHIFT_CNT_REG, OP_SHIFT_IMM: begin
        if (m[5:3] == SHIFT_UNDEF) begin
          r = OP_BAD;
        end
      end
      default: r = o;
    endcase
    return r;
  endfunction

  function automatic logic needs_modrm(input op_e o);
    return o inside {OP_GRP3, OP_SHIFT1, OP_SHIFT_CNT_REG, OP_SHIFT_IMM,
                     OP_AND_IMM, OP_TEST_RM, OP_GRP5};
  endfunction

  function automatic logic has_modrm(input op_e o);
    return needs_modrm(o) || (o inside {OP_DIVIDE, OP_TEST_IMM, OP_NOT,
      OP_CALL_IND, OP_JMP_IND, OP_CALL_FAR_IND, OP_JMP_FAR_IND});
  endfunction

  function automatic logic is_string(input op_e o);
    return o inside {OP_STR_MOVE, OP_STR_CMP, OP_STR_SCAN, OP_STR_LOAD,
                     OP_STR_STORE, OP_STR_IN, OP_STR_OUT};
  endfunction

  function automatic logic has_w(input op_e o);
    return is_string(o) || (has_modrm(o) && o != OP_GRP5 &&
      !(o inside {OP_CALL_IND, OP_JMP_IND, OP_CALL_FAR_IND,
                  OP_JMP_FAR_IND})) || o == OP_AND_ACC ||
      o == OP_TEST_ACC;
  endfunction

  function automatic logic [1:0] disp_len(input logic [7:0] m);
    logic [1:0] n;
    n = 2'h0;
    case (m[7:6])
      MOD_NO_DISP: n = (m[2:0] == RM_DIRECT) ? 2'h2 : 2'h0;
      MOD_DISP8: n = 2'h1;
      MOD_DISP16: n = 2'h2;
      default: n = 2'h0;
    endcase
    return n;
  endfunction

  // data bytes that follow an opcode or a modifier byte
  function automatic logic [2:0] imm_len(input op_e o, input logic w);
    logic [2:0] n;
    n = 3'h0;
    case (o)
      OP_AND_IMM, OP_TEST_IMM, OP_AND_ACC, OP_TEST_ACC:
        n = w ? 3'h2 : 3'h1;
      OP_SHIFT_IMM: n = 3'h1;
      OP_CALL_NEAR, OP_RET_NEAR_IMM, OP_RET_FAR_IMM: n = 3'h2;
      OP_CALL_FAR, OP_JMP_FAR: n = 3'h4;
      default: n = 3'h0;
    endcase
    return n;
  endfunction

  function automatic cyc_t calc_cycles(input op_e o, input logic w,
    input logic mem, input logic rep, input logic [7:0] n,
    input logic [15:0] reps);
    cyc_t c;
    cyc_t wm;
    cyc_t fix;
    cyc_t per;
    cyc_t xfer;
    c = '0;
    fix = '0;
    per = '0;
    xfer = CYC_WORD_XFER;
    wm = (w && mem) ? CYC_WORD_XFER : '0;
    case (o)
      OP_DIVIDE: c = CYC_DIV_SPREAD + (mem ? (w ? CYC_DIV_MW : CYC_DIV_MB)
                     : (w ? CYC_DIV_RW : CYC_DIV_RB));
      OP_ADJ_MUL: c = CYC_ADJ_MUL;
      OP_ADJ_DIV: c = CYC_ADJ_DIV;
      OP_BYTE_EXT: c = CYC_BYTE_EXT;
      OP_WORD_EXT: c = CYC_WORD_EXT;
      OP_SHIFT1: c = (mem ? CYC_SH1_M : CYC_SH1_R) + wm;
      OP_SHIFT_CNT_REG, OP_SHIFT_IMM:
        c = (mem ? CYC_SHN_M : CYC_SHN_R) + {16'h0000, n} + wm;
      OP_AND_IMM: c = (mem ? CYC_AND_IMM_M : CYC_AND_IMM_R) + wm;
      OP_AND_ACC, OP_TEST_ACC: c = w ? CYC_ACC_W : CYC_ACC_B;
      OP_TEST_RM: c = (mem ? CYC_TEST_M : CYC_TEST_RM_R) + wm;
      OP_TEST_IMM: c = (mem ? CYC_TEST_M : CYC_TEST_IMM_R) + wm;
      OP_NOT: c = CYC_NOT;
      OP_CALL_NEAR: c = CYC_CALL_NEAR;
      OP_CALL_IND: c = mem ? CYC_CALL_IND_M : CYC_CALL_IND_R;
      OP_JMP_IND: c = mem ? CYC_JMP_IND_M : CYC_JMP_IND_R;
      OP_CALL_FAR: c = CYC_CALL_FAR;
      OP_JMP_FAR: c = CYC_JMP_FAR;
      OP_CALL_FAR_IND: c = CYC_CALL_FAR_IND;
      OP_JMP_FAR_IND: c = CYC_JMP_FAR_IND;
      OP_RET_NEAR: c = CYC_RET_NEAR;
      OP_RET_NEAR_IMM: c = CYC_RET_NEAR_IMM;
      OP_RET_FAR: c = CYC_RET_FAR;
      OP_RET_FAR_IMM: c = CYC_RET_FAR_IMM;
      default: c = '0;
    endcase
    // string costs: single, repeat fixed part, repeat per element
    case (o)
      OP_STR_MOVE: begin
        c = 24'h00000E; fix = 24'h000008; per = 24'h000008;
        xfer = CYC_WORD_XFER + CYC_WORD_XFER;
      end
      OP_STR_CMP: begin
        c = 24'h000016; fix = 24'h000005; per = 24'h000016;
        xfer = CYC_WORD_XFER + CYC_WORD_XFER;
      end
      OP_STR_SCAN: begin
        c = 24'h00000F; fix = 24'h000005; per = 24'h00000F;
      end
      OP_STR_LOAD: begin
        c = 24'h00000C; fix = 24'h000006; per = 24'h00000B;
      end
      OP_STR_STORE: begin
        c = 24'h00000A; fix = 24'h000006; per = 24'h000009;
      end
      OP_STR_IN, OP_STR_OUT: begin
        c = 24'h00000E; fix = 24'h000008; per = 24'h000008;
      end
      default: xfer = CYC_WORD_XFER;
    endcase
    if (is_string(o)) begin
      if (w) begin
        c = c + xfer;
        per = per + xfer;
      end
      if (rep) begin
        c = fix + ({8'h00, reps} * per);
      end
    end
    return c;
  endfunction

  dstate_e state_ff, nxt_state;
  logic [7:0] opc_ff, nxt_opc;
  logic [7:0] modrm_ff, nxt_modrm;
  logic [7:0] cnt_ff, nxt_cnt;
  op_e op_ff, nxt_op;
  logic rep_ff, nxt_rep;
  logic repz_ff, nxt_repz;
  logic [1:0] disp_ff, nxt_disp;
  logic [2:0] imm_ff, nxt_imm;
  cyc_t cyc_ff, nxt_cyc;
  dec_s dec_ff, nxt_dec;
  logic ready_ff, nxt_ready;
  logic busy_ff, nxt_busy;
  logic take;
  logic finish;
  logic bad;
  logic w_eff;
  logic mem_eff;
  logic timer_done;
  cyc_t timer_val;

  assign take = fetch_in.valid && ready_ff;
  assign w_eff = has_w(nxt_op) && nxt_opc[0];
  assign mem_eff = has_modrm(nxt_op) && (nxt_modrm[7:6] != MOD_REG);
  assign timer_val = nxt_cyc - 24'h000001;

  always_comb begin
    nxt_state = state_ff;
    nxt_opc = opc_ff;
    nxt_modrm = modrm_ff;
    nxt_cnt = cnt_ff;
    nxt_op = op_ff;
    nxt_rep = rep_ff;
    nxt_repz = repz_ff;
    nxt_disp = disp_ff;
    nxt_imm = imm_ff;
    nxt_dec = dec_ff;
    nxt_dec.valid = 1'b0;
    finish = 1'b0;
    bad = 1'b0;
    unique case (state_ff)
      ST_OPC: begin
        if (take && fetch_in.data[7:1] == OPC_REP[7:1] && !rep_ff) begin
          nxt_rep = 1'b1;
          nxt_repz = fetch_in.data[0];
        end else if (take) begin
          nxt_opc = fetch_in.data;
          nxt_op = classify(fetch_in.data);
          nxt_modrm = '0;
          nxt_cnt = '0;
          nxt_imm = imm_len(nxt_op, fetch_in.data[0]);
          // only compare and scan honour the z form of the prefix
          if (rep_ff && (!is_string(nxt_op) || (repz_ff &&
              !(nxt_op inside {OP_STR_CMP, OP_STR_SCAN})))) begin
            bad = 1'b1;
          end else if (nxt_op == OP_BAD) begin
            bad = 1'b1;
          end else if (needs_modrm(nxt_op)) begin
            nxt_state = ST_MODRM;
          end else if (nxt_op == OP_ADJ_MUL || nxt_op == OP_ADJ_DIV) begin
            nxt_state = ST_ADJ;
          end else if (nxt_imm != 3'h0) begin
            nxt_state = ST_IMM;
          end else begin
            finish = 1'b1;
          end
        end
      end
      ST_ADJ: begin
        if (take) begin
          bad = (fetch_in.data != ADJ_TAIL);
          finish = (fetch_in.data == ADJ_TAIL);
        end
      end
      ST_MODRM: begin
        if (take) begin
          nxt_modrm = fetch_in.data;
          nxt_op = resolve(op_ff, fetch_in.data);
          nxt_disp = disp_len(fetch_in.data);
          nxt_imm = imm_len(nxt_op, opc_ff[0]);
          if (nxt_op == OP_BAD) begin
            bad = 1'b1;
          end else if (nxt_disp != 2'h0) begin
            nxt_state = ST_DISP;
          end else if (nxt_imm != 3'h0) begin
            nxt_state = ST_IMM;
          end else begin
            finish = 1'b1;
          end
        end
      end
      ST_DISP: begin
        if (take) begin
          nxt_disp = disp_ff - 2'h1;
          if (disp_ff == 2'h1) begin
            nxt_state = (imm_ff != 3'h0) ? ST_IMM : ST_DISP;
            finish = (imm_ff == 3'h0);
          end
        end
      end
      ST_IMM: begin
        if (take) begin
          // the immediate count byte of a shift is its count
          if (op_ff == OP_SHIFT_IMM) begin
            nxt_cnt = fetch_in.data;
          end
          nxt_imm = imm_ff - 3'h1;
          finish = (imm_ff == 3'h1);
        end
      end
      ST_EXEC: begin
        if (timer_done) begin
          nxt_state = ST_OPC;
          nxt_rep = 1'b0;
          nxt_repz = 1'b0;
          nxt_dec.valid = 1'b1;
          nxt_dec.bad = 1'b0;
          nxt_dec.op = op_ff;
          nxt_dec.shift_op = (op_ff inside {OP_SHIFT1, OP_SHIFT_CNT_REG,
            OP_SHIFT_IMM}) ? shift_op_e'(modrm_ff[5:3]) : ROTATE_LEFT;
          nxt_dec.wide = has_w(op_ff) && opc_ff[0];
          nxt_dec.mem = has_modrm(op_ff) && (modrm_ff[7:6] != MOD_REG);
          nxt_dec.rep = rep_ff;
          nxt_dec.rep_z = repz_ff;
          nxt_dec.cycles = cyc_ff;
        end
      end
      default: begin
        nxt_state = ST_OPC;
      end
    endcase
    // shift by count register reads it when the last byte is taken
    nxt_cyc = calc_cycles(nxt_op, w_eff, mem_eff, nxt_rep,
      (nxt_op == OP_SHIFT_CNT_REG) ? count_reg_low_byte : nxt_cnt,
      count_register);
    if (!finish) begin
      nxt_cyc = cyc_ff;
    end else begin
      nxt_state = ST_EXEC;
    end
    if (bad) begin
      nxt_state = ST_OPC;
      nxt_rep = 1'b0;
      nxt_repz = 1'b0;
      nxt_dec = '0;
      nxt_dec.valid = 1'b1;
      nxt_dec.bad = 1'b1;
      nxt_dec.op = OP_BAD;
    end
    nxt_ready = (nxt_state != ST_EXEC);
    nxt_busy = (nxt_state != ST_OPC) || nxt_rep;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= ST_OPC;
      opc_ff <= 8'h00;
      modrm_ff <= 8'h00;
      cnt_ff <= 8'h00;
      op_ff <= OP_BAD;
      rep_ff <= 1'b0;
      repz_ff <= 1'b0;
      disp_ff <= 2'h0;
      imm_ff <= 3'h0;
      cyc_ff <= '0;
      dec_ff <= '0;
      ready_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      opc_ff <= nxt_opc;
      modrm_ff <= nxt_modrm;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
      rep_ff <= nxt_rep;
      repz_ff <= nxt_repz;
      disp_ff <= nxt_disp;
      imm_ff <= nxt_imm;
      cyc_ff <= nxt_cyc;
      dec_ff <= nxt_dec;
      ready_ff <= nxt_ready;
      busy_ff <= nxt_busy;
    end
  end

  // a cycle count of n gives a result pulse n edges after the last byte
  cycle_timer u_timer (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .load(finish),
    .load_val(timer_val),
    .done(timer_done)
  );

  assign fetch_ready = ready_ff;
  assign busy = busy_ff;
  assign dec_out = dec_ff;

endmodule

// ===== dv/decode_checker_assertions.sv
// concurrent checks on the opcode decoder ports
`timescale 1ns/10ps
module decode_checker
  import decode_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  input wire fetch_s fetch_in,
  input wire logic [7:0] count_reg_low_byte,
  input wire logic [15:0] count_register,
  input wire logic fetch_ready,
  input wire logic busy,
  input wire dec_s dec_out
);
  cyc_t lo_cnt;
  wire fin = dec_out.valid && !dec_out.bad;
  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // edges seen since the last byte was taken, so latency is exact
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b)
      lo_cnt <= '0;
    else
      lo_cnt <= fetch_ready ? '0 : lo_cnt + 24'h000001;
  end
  a_exec_len:
  assert property (fin |-> lo_cnt == dec_out.cycles)
    else $error("result pulse not at the reported cost");
  a_ready_back:
  assert property (dec_out.valid |-> fetch_ready)
    else $error("fetch not reopened with the result");
  a_busy_exec:
  assert property ($fell(fetch_ready) |-> busy)
    else $error("not busy while executing");
  a_bad_fields:
  assert property (dec_out.valid && dec_out.bad |->
    dec_out.op == OP_BAD && dec_out.cycles == 24'h000000)
    else $error("refused result carries fields");
  a_div_cost:
  assert property (fin && dec_out.op == OP_DIVIDE |-> dec_out.cycles ==
    (dec_out.mem ? (dec_out.wide ? 67 : 58) : (dec_out.wide ? 61 : 52)))
    else $error("divide cost wrong");
  a_adj_cost:
  assert property (fin && dec_out.op inside {OP_ADJ_MUL, OP_ADJ_DIV} |->
    dec_out.cycles == (dec_out.op == OP_ADJ_MUL ? 19 : 15))
    else $error("adjust cost wrong");
  a_shift_one:
  assert property (fin && dec_out.op == OP_SHIFT1 |->
    dec_out.shift_op != SHIFT_UNDEF &&
    dec_out.cycles == (dec_out.mem ? (dec_out.wide ? 19 : 15) : 2))
    else $error("shift by one wrong");
  a_far_ind_mem:
  assert property (fin && dec_out.op inside {OP_CALL_FAR_IND,
    OP_JMP_FAR_IND} |-> dec_out.mem)
    else $error("far indirect on a register accepted");
  a_ret_cost:
  assert property (fin && dec_out.op == OP_RET_FAR_IMM |->
    dec_out.cycles == 33)
    else $error("far return cost wrong");
  c_bad: cover property (dec_out.valid && dec_out.bad);
  c_rep: cover property (fin && dec_out.rep);
  c_mem: cover property (fin && dec_out.mem);
endmodule

// ===== dv/tb_opcode_decode.sv
// self-checking bench for the opcode decoder
`timescale 1ns/10ps
module tb_opcode_decode;
  import decode_pkg::*;
  logic core_clk, rst_b, fetch_ready, busy;
  fetch_s fetch_in;
  logic [7:0] count_reg_low_byte, n, m;
  logic [15:0] count_register;
  dec_s dec_out;
  int n_errors, samples_checked, seed;
  opcode_decode opcode_decode_inst(.core_clk(core_clk), .rst_b(rst_b),
    .fetch_in(fetch_in), .count_reg_low_byte(count_reg_low_byte),
    .count_register(count_register), .fetch_ready(fetch_ready),
    .busy(busy), .dec_out(dec_out));
  task automatic chk(input cyc_t got, input cyc_t exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // cost 1 means refused: the pulse comes with the offending byte's edge
  task automatic run(input logic [7:0] b[$], input cyc_t c);
    cyc_t lat;
    lat = 0;
    foreach (b[i]) begin
      fetch_in = {1'b1, b[i]};
      while (fetch_ready !== 1'b1) begin
        @(posedge core_clk);
        #1;
      end
      @(posedge core_clk);
      #1;
    end
    fetch_in = {1'b0, ~b[b.size()-1]};
    while (dec_out.valid !== 1'b1 && lat < 24'h000FA0) begin
      @(posedge core_clk);
      #1;
      lat++;
    end
    chk(lat, c == 1 ? 24'h000000 : c);
    chk(busy, 1'b0);
    chk(dec_out.cycles, c == 1 ? 24'h000000 : c);
    chk(dec_out.bad, c == 1);
    $display("done cost %0d", c);
  endtask
  task tally_and_finish();
    $display("checked %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    core_clk = 0;
    forever #5 core_clk = ~core_clk;
  end
  // far above the longest expected run of the sequence below
  initial begin
    #300000;
    n_errors++;
    tally_and_finish();
  end
  initial begin
    seed = 56896;
    n_errors = 0;
    samples_checked = 0;
    rst_b = 0;
    fetch_in = '0;
    count_reg_low_byte = 8'h00;
    count_register = 16'h0000;
    repeat (2) @(posedge core_clk);
    #1 rst_b = 1;
    for (int t = 0; t < 8; t++) begin
      m = {2'b11, t[2:0], 3'b000};
      run({8'hD0, m}, t == 6 ? 1 : 2);
      if (t != 6) chk(dec_out.shift_op, t[2:0]);
    end
    run({8'hD1, 8'h26, 8'h00, 8'h01}, 19);
    n = $random(seed);
    count_reg_low_byte = n;
    run({8'hD2, 8'hC3}, 5 + n);
    run({8'hC1, 8'h06, 8'h34, 8'h12, n}, 21 + n);
    count_register = $random(seed) & 16'h001F;
    run({8'hF2, 8'hA4}, 8 + 8 * count_register);
    chk(dec_out.rep, 1'b1);
    run({8'hF3, 8'hA7}, 5 + 30 * count_register);
    chk(dec_out.rep_z, 1'b1);
    run({8'hF3, 8'hA4}, 1);
    run({8'hF6, 8'hF8}, 52);
    run({8'hF7, 8'h38}, 67);
    chk(dec_out.op, OP_DIVIDE);
    chk({dec_out.wide, dec_out.mem}, 2'h3);
    run({8'hD4, 8'h0A}, 19);
    run({8'hD5, 8'h0A}, 15);
    run({8'hD5, 8'h0B}, 1);
    run({8'h98}, 2);
    run({8'h99}, 4);
    run({8'h81, 8'h60, 8'h07, 8'h11, 8'h22}, 20);
    run({8'h80, 8'hC8}, 1);
    run({8'h25, 8'h01, 8'h02}, 4);
    run({8'h84, 8'hC1}, 3);
    run({8'hF6, 8'h00, 8'h5A}, 10);
    run({8'hA8, 8'h5A}, 3);
    run({8'hF7, 8'hD3}, 3);
    run({8'hA7}, 30);
    run({8'hAB}, 14);
    run({8'h6C}, 14);
    run({8'hE8, 8'h00, 8'h10}, 19);
    run({8'hFF, 8'h16, 8'h00, 8'h20}, 27);
    run({8'hFF, 8'hE0}, 11);
    run({8'h9A, 8'h01, 8'h02, 8'h03, 8'h04}, 31);
    run({8'hFF, 8'h58, 8'h09}, 54);
    run({8'hFF, 8'hE8}, 1);
    run({8'hCA, 8'h04, 8'h00}, 33);
    tally_and_finish();
  end
endmodule
bind opcode_decode decode_checker decode_checker_inst(.core_clk(core_clk),
  .rst_b(rst_b), .fetch_in(fetch_in),
  .count_reg_low_byte(count_reg_low_byte), .count_register(count_register),
  .fetch_ready(fetch_ready), .busy(busy), .dec_out(dec_out));
